// file: verilog/cwd_decode.sv
/*
  Decodes configuration word one into static control levels, erase
  requests on protection turn-off, and reset/oscillator gating.
  Assumes the word is stable outside programming mode and that the
  external reset pin and sleep state are asynchronous levels.
*/
`timescale 1ns/1ps
`default_nettype none
module cwd_decode
  import cwd_pkg::*;
(
  input  wire logic                 i_core_clk,
  input  wire logic                 i_reset_n,
  input  wire logic [13:0]          i_configuration_word_one,
  input  wire logic                 i_prog_mode,
  input  wire logic                 i_cfg_write,
  input  wire logic [13:0]          i_cfg_wdata,
  input  wire logic                 i_ext_reset_pin,
  input  wire logic                 i_sleep,
  input  wire logic                 i_brownout_soft_en,
  input  wire logic                 i_watchdog_soft_en,
  output logic                      o_cfg_wr_en,
  output logic [13:0]               o_cfg_wdata,
  output cwd_pkg::cwd_ctrl_t        o_ctrl,
  output cwd_pkg::cwd_erase_t       o_erase,
  output logic                      o_ext_reset_active,
  output logic                      o_ext_reset_pin_input,
  output logic                      o_osc_stop
);
  import cwd_pkg::*;

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire logic rst_n = rst_s2_q;

  // ------------------------------------------------------------
  // Pin synchronisers: three stages, change counted when 2 and 3 agree
  // ------------------------------------------------------------
  logic [2:0] pin_d;
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;
  logic [2:0] pin_f_q;
  logic [2:0] pin_f_d;
  assign pin_d = {i_ext_reset_pin, i_sleep, i_prog_mode};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pin
      always_comb begin
        pin_f_d[g] = (pin_s2_q[g] == pin_s3_q[g]) ? pin_s3_q[g] : pin_f_q[g];
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Idle levels, so no false external reset burst follows release
      pin_s1_q <= PIN_IDLE;
      pin_s2_q <= PIN_IDLE;
      pin_s3_q <= PIN_IDLE;
      pin_f_q  <= PIN_IDLE;
    end else begin
      pin_s1_q <= pin_d;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q  <= pin_f_d;
    end
  end
  wire logic prog_mode = pin_f_q[0];
  wire logic sleeping  = pin_f_q[1];
  wire logic rst_pin   = pin_f_q[2];

  // ------------------------------------------------------------
  // Word capture and decode
  // ------------------------------------------------------------
  logic [13:0] word_q;
  logic [13:0] word_d;
  cwd_ctrl_t   ctrl_q;
  cwd_ctrl_t   ctrl_d;
  cwd_erase_t  erase_q;
  cwd_erase_t  erase_d;
  logic        cfg_wr_q;
  logic        cfg_wr_d;
  logic [13:0] cfg_wdata_q;
  logic [13:0] cfg_wdata_d;
  logic        osc_stop_q;
  logic        osc_stop_d;
  logic        rst_act_q;
  logic        rst_act_d;
  logic        pin_in_q;
  logic        pin_in_d;

  function automatic logic osc_is_rc_or_int(input cwd_osc_t m);
    unique case (m)
      OSC_INT_IO, OSC_INT_CK, OSC_RC_IO, OSC_RC_CK: osc_is_rc_or_int = 1'b1;
      default:                                      osc_is_rc_or_int = 1'b0;
    endcase
  endfunction

  always_comb begin
    cwd_bor_t bor;
    bor    = cwd_bor_t'(word_q[BIT_BOR_HI:BIT_BOR_LO]);
    word_d = i_configuration_word_one;
    ctrl_d.debug_pins_gpio           = word_q[BIT_DEBUG];
    ctrl_d.low_volt_prog_en          = word_q[BIT_LVP];
    ctrl_d.failsafe_clock_monitor_en = word_q[BIT_FSCM];
    ctrl_d.int_ext_switchover_en     = word_q[BIT_SWITCH];
    ctrl_d.data_code_protect         = ~word_q[BIT_DATA_CP];
    ctrl_d.program_code_protect      = ~word_q[BIT_PROG_CP];
    ctrl_d.ext_reset_pin_select      = word_q[BIT_RST_SEL];
    ctrl_d.powerup_delay_en_n        = word_q[BIT_PWRUP];
    ctrl_d.watchdog_en = word_q[BIT_WDOG] | i_watchdog_soft_en;
    ctrl_d.osc_mode_select = cwd_osc_t'(word_q[BIT_OSC_HI:BIT_OSC_LO]);
    unique case (bor)
      BOR_OFF:  ctrl_d.brownout_en = 1'b0;
      BOR_SOFT: ctrl_d.brownout_en = i_brownout_soft_en;
      BOR_NSLP: ctrl_d.brownout_en = ~sleeping;
      BOR_ON:   ctrl_d.brownout_en = 1'b1;
    endcase
    // Protection turning off (0 -> 1 bit) wipes the guarded array
    erase_d.erase_data = ~word_q[BIT_DATA_CP] & i_configuration_word_one[BIT_DATA_CP];
    erase_d.erase_prog = ~word_q[BIT_PROG_CP] & i_configuration_word_one[BIT_PROG_CP];
    // Firmware can never reach the word; gate on programming mode
    cfg_wr_d    = i_cfg_write & prog_mode;
    cfg_wdata_d = i_cfg_wdata;
    rst_act_d   = word_q[BIT_RST_SEL] & ~rst_pin;
    pin_in_d    = ~word_q[BIT_RST_SEL];
    osc_stop_d  = rst_act_d & osc_is_rc_or_int(ctrl_d.osc_mode_select);
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_q      <= CFG_ERASED;
      ctrl_q      <= '0;
      erase_q     <= '0;
      cfg_wr_q    <= 1'b0;
      cfg_wdata_q <= 14'h0000;
      rst_act_q   <= 1'b0;
      pin_in_q    <= 1'b0;
      osc_stop_q  <= 1'b0;
    end else begin
      word_q      <= word_d;
      ctrl_q      <= ctrl_d;
      erase_q     <= erase_d;
      cfg_wr_q    <= cfg_wr_d;
      cfg_wdata_q <= cfg_wdata_d;
      rst_act_q   <= rst_act_d;
      pin_in_q    <= pin_in_d;
      osc_stop_q  <= osc_stop_d;
    end
  end

  assign o_ctrl                = ctrl_q;
  assign o_erase               = erase_q;
  assign o_cfg_wr_en           = cfg_wr_q;
  assign o_cfg_wdata           = cfg_wdata_q;
  assign o_ext_reset_active    = rst_act_q;
  assign o_ext_reset_pin_input = pin_in_q;
  assign o_osc_stop            = osc_stop_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_debug;
    @(posedge i_core_clk) disable iff (!rst_n)
      // Sampled reset skips the release edge, when outputs still hold reset values
      rst_n |=> o_ctrl.debug_pins_gpio == $past(word_q[BIT_DEBUG]);
  endproperty
  a_debug: assert property (p_debug) else $error("debug pin select wrong");

  property p_lvp;
    @(posedge i_core_clk) disable iff (!rst_n)
      rst_n |=> o_ctrl.low_volt_prog_en == $past(word_q[BIT_LVP]);
  endproperty
  a_lvp: assert property (p_lvp) else $error("low voltage entry wrong");

  property p_bor_sleep;
    @(posedge i_core_clk) disable iff (!rst_n)
      (word_q[BIT_BOR_HI:BIT_BOR_LO] == 2'b10 && sleeping) |=> !o_ctrl.brownout_en;
  endproperty
  a_bor_sleep: assert property (p_bor_sleep) else $error("brown-out on in sleep");

  property p_bor_fixed;
    @(posedge i_core_clk) disable iff (!rst_n)
      (rst_n && word_q[BIT_BOR_HI] == word_q[BIT_BOR_LO])
        |=> o_ctrl.brownout_en == $past(word_q[BIT_BOR_HI]);
  endproperty
  a_bor_fixed: assert property (p_bor_fixed) else $error("fixed brown-out wrong");

  property p_data_cp;
    @(posedge i_core_clk) disable iff (!rst_n)
      !word_q[BIT_DATA_CP] |=> o_ctrl.data_code_protect;
  endproperty
  a_data_cp: assert property (p_data_cp) else $error("data protect missing");

  sequence s_cp_drop(int b);
    !word_q[b] ##1 word_q[b];
  endsequence
  property p_erase_data;
    @(posedge i_core_clk) disable iff (!rst_n)
      s_cp_drop(BIT_DATA_CP) |-> o_erase.erase_data;
  endproperty
  a_erase_data: assert property (p_erase_data) else $error("data erase missing");

  property p_erase_prog;
    @(posedge i_core_clk) disable iff (!rst_n)
      s_cp_drop(BIT_PROG_CP) |-> o_erase.erase_prog;
  endproperty
  a_erase_prog: assert property (p_erase_prog) else $error("program erase missing");

  property p_rst_tie;
    @(posedge i_core_clk) disable iff (!rst_n)
      !word_q[BIT_RST_SEL] |=> !o_ext_reset_active && o_ext_reset_pin_input;
  endproperty
  a_rst_tie: assert property (p_rst_tie) else $error("reset not tied off");

  property p_wdog;
    @(posedge i_core_clk) disable iff (!rst_n)
      (rst_n && word_q[BIT_WDOG]) |=> o_ctrl.watchdog_en;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog not forced");

  property p_osc_stop;
    @(posedge i_core_clk) disable iff (!rst_n)
      (o_ext_reset_active && $past(word_q[BIT_OSC_HI])) |-> o_osc_stop;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator not stopped");

  property p_wr_gate;
    @(posedge i_core_clk) disable iff (!rst_n)
      !prog_mode |=> !o_cfg_wr_en;
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("write outside programming");
endmodule
`default_nettype wire

// file: verilog/cwd_pkg.sv
/*
  Constants and carrier types for the configuration word one decoder.
  Assumes a 14-bit configuration word delivered from non-volatile storage.
*/
`default_nettype none
package cwd_pkg;
  // ------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------
  localparam int unsigned CFG_W          = 14;
  localparam int unsigned BIT_DEBUG      = 13;
  localparam int unsigned BIT_LVP        = 12;
  localparam int unsigned BIT_FSCM       = 11;
  localparam int unsigned BIT_SWITCH     = 10;
  localparam int unsigned BIT_BOR_HI     = 9;
  localparam int unsigned BIT_BOR_LO     = 8;
  localparam int unsigned BIT_DATA_CP    = 7;
  localparam int unsigned BIT_PROG_CP    = 6;
  localparam int unsigned BIT_RST_SEL    = 5;
  localparam int unsigned BIT_PWRUP      = 4;
  localparam int unsigned BIT_WDOG       = 3;
  localparam int unsigned BIT_OSC_HI     = 2;
  localparam int unsigned BIT_OSC_LO     = 0;
  // Erased word: every bit unprogrammed
  localparam logic [13:0] CFG_ERASED     = 14'h3FFF;
  // Pin filters rest at idle: reset pin high, awake, not programming
  localparam logic [2:0]  PIN_IDLE       = 3'h4;

  // ------------------------------------------------------------
  // Field encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    BOR_OFF   = 2'b00,
    BOR_SOFT  = 2'b01,
    BOR_NSLP  = 2'b10,
    BOR_ON    = 2'b11
  } cwd_bor_t;

  typedef enum logic [2:0] {
    OSC_LP     = 3'b000,
    OSC_XT     = 3'b001,
    OSC_HS     = 3'b010,
    OSC_EC     = 3'b011,
    OSC_INT_IO = 3'b100,
    OSC_INT_CK = 3'b101,
    OSC_RC_IO  = 3'b110,
    OSC_RC_CK  = 3'b111
  } cwd_osc_t;

  typedef struct packed {
    logic     debug_pins_gpio;
    logic     low_volt_prog_en;
    logic     failsafe_clock_monitor_en;
    logic     int_ext_switchover_en;
    logic     data_code_protect;
    logic     program_code_protect;
    logic     ext_reset_pin_select;
    logic     powerup_delay_en_n;
    logic     watchdog_en;
    logic     brownout_en;
    cwd_osc_t osc_mode_select;
  } cwd_ctrl_t;

  typedef struct packed {
    logic erase_data;
    logic erase_prog;
  } cwd_erase_t;
endpackage
`default_nettype wire

// file: tb/cwd_prog_model.sv
/*
  Behavioural programmer on the far side of the configuration word.
  Assumes the caller sequences start and stop on the bench clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cwd_prog_model (
  input  wire logic        i_core_clk,
  output logic             o_prog_mode,
  output logic             o_cfg_write,
  output logic [13:0]      o_cfg_wdata
);
  initial begin
    o_prog_mode = 1'h0;
    o_cfg_write = 1'h0;
    o_cfg_wdata = 14'h0000;
  end
  // A legal write enters programming mode first and lets the filter settle
  task automatic start(input logic [13:0] d, input logic legal);
    @(posedge i_core_clk) #1;
    o_prog_mode = legal;
    repeat (4) @(posedge i_core_clk);
    #1;
    o_cfg_write = 1'h1;
    o_cfg_wdata = d;
  endtask
  // Released data shows the inverse, so a stale copy cannot pass
  task automatic stop();
    @(posedge i_core_clk) #1;
    o_cfg_write = 1'h0;
    o_cfg_wdata = ~o_cfg_wdata;
    o_prog_mode = 1'h0;
  endtask
endmodule
`default_nettype wire

// file: tb/cwd_decode_tb_top.sv
/*
  Self-checking bench for the configuration word one decoder.
  Assumes every decoded level settles within eight clocks of a change.
*/
`timescale 1ns/1ps
`default_nettype none
module cwd_decode_tb_top;
  import cwd_pkg::*;
  logic        clk, rst_n, pin, slp, bsoft, wsoft, pmode, wr, o_wr, o_act, o_pin_in, o_stop;
  logic [13:0] word, wdata, o_wd;
  cwd_ctrl_t   o_ctrl;
  cwd_erase_t  o_erase;
  int          mismatches, n_tests;
  initial clk = 1'h0;
  always #2.5 clk = ~clk;
  cwd_prog_model prog (.i_core_clk(clk), .o_prog_mode(pmode), .o_cfg_write(wr),
                       .o_cfg_wdata(wdata));
  cwd_decode uut (.i_core_clk(clk), .i_reset_n(rst_n), .i_configuration_word_one(word),
    .i_prog_mode(pmode), .i_cfg_write(wr), .i_cfg_wdata(wdata), .i_ext_reset_pin(pin),
    .i_sleep(slp), .i_brownout_soft_en(bsoft), .i_watchdog_soft_en(wsoft),
    .o_cfg_wr_en(o_wr), .o_cfg_wdata(o_wd), .o_ctrl(o_ctrl), .o_erase(o_erase),
    .o_ext_reset_active(o_act), .o_ext_reset_pin_input(o_pin_in), .o_osc_stop(o_stop));
  // ------------------------------------------------------------
  // Expectations and comparisons
  // ------------------------------------------------------------
  function automatic cwd_ctrl_t exp_ctrl(input logic [13:0] w, input logic s, b, d);
    logic bo;
    case (w[9:8])
      2'h0: bo = 1'h0;
      2'h1: bo = b;
      2'h2: bo = ~s;
      default: bo = 1'h1;
    endcase
    return '{w[13], w[12], w[11], w[10], ~w[7], ~w[6], w[5], w[4], w[3] | d, bo,
             cwd_osc_t'(w[2:0])};
  endfunction
  task automatic chk_ctrl(input cwd_ctrl_t got, input cwd_ctrl_t exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [13:0] got, input logic [13:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apply(input logic [13:0] w, input logic p, s, b, d);
    @(posedge clk) #1;
    word = w;
    pin = p;
    slp = s;
    bsoft = b;
    wsoft = d;
    repeat (8) @(posedge clk);
    #1;
    chk_ctrl(o_ctrl, exp_ctrl(w, s, b, d));
    chk_bit(o_act, ~p & w[5]);
    chk_bit(o_pin_in, ~w[5]);
    chk_bit(o_stop, ~p & w[5] & w[2]);
  endtask
  // Protection off must give exactly one erase pulse; turning it on gives none
  task automatic erase_case(input int b);
    logic [13:0] w;
    int hd, hp, on;
    for (on = 0; on < 2; on++) begin
      w = 14'h3FFF;
      w[b] = on[0];
      apply(w, 1'h1, 1'h0, 1'h0, 1'h0);
      w[b] = ~on[0];
      hd = 0;
      hp = 0;
      @(posedge clk) #1;
      word = w;
      repeat (8) begin
        @(posedge clk) #1;
        hd += int'(o_erase.erase_data === 1'h1);
        hp += int'(o_erase.erase_prog === 1'h1);
      end
      chk_val(14'(hd), 14'((b == 7 && on == 0) ? 1 : 0));
      chk_val(14'(hp), 14'((b == 6 && on == 0) ? 1 : 0));
    end
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [13:0] w;
    int k;
    mismatches = 0;
    n_tests = 0;
    rst_n = 1'h0;
    word = CFG_ERASED;
    pin = 1'h1;
    slp = 1'h0;
    bsoft = 1'h0;
    wsoft = 1'h0;
    void'($urandom(32'h41bacf59));
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'h1;
    apply(CFG_ERASED, 1'h1, 1'h0, 1'h0, 1'h0);
    for (k = 0; k < 64; k++) begin
      w = 14'h3FFF;
      w[9:8] = k[1:0];
      w[2:0] = k[4:2];
      apply(w, 1'h0, k[5], 1'($urandom), 1'($urandom));
    end
    for (k = 0; k < 40; k++) begin
      apply(14'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
    end
    erase_case(7);
    erase_case(6);
    w = 14'($urandom);
    prog.start(w, 1'h1);
    k = 0;
    while (o_wr !== 1'h1 && k < 12) begin
      @(posedge clk) #1;
      k++;
    end
    if (k == 12) begin
      mismatches++;
      conclude();
    end
    chk_val(o_wd, w);
    prog.stop();
    prog.start(~w, 1'h0);
    repeat (10) begin
      @(posedge clk) #1;
      chk_bit(o_wr, 1'h0);
    end
    prog.stop();
    conclude();
  end
endmodule
`default_nettype wire
